// ===== core/bfd_map.svh
`ifndef BFD_MAP_SVH
`define BFD_MAP_SVH
// bit positions are in big-endian numbering: bit 0 is the msb of the word
`define BFD_OPC_HI 0
`define BFD_OPC_LO 5
`define BFD_F1_HI 6
`define BFD_F1_LO 10
`define BFD_F2_HI 11
`define BFD_F2_LO 15
`define BFD_F3_HI 16
`define BFD_F3_LO 20
`define BFD_MB_HI 21
`define BFD_MB_LO 25
`define BFD_ME_HI 26
`define BFD_ME_LO 30
`define BFD_RC_BIT 31
`define BFD_AA_BIT 30
`define BFD_LI_HI 6
`define BFD_LI_LO 29
`define BFD_BD_HI 16
`define BFD_BD_LO 29
`define BFD_GRP_HI 8
`define BFD_SGRP_HI 13
`define BFD_GRP_BITS 4
`define BFD_ALIGN_BITS 2
`define BFD_DEC_LATENCY 1
`endif

// ===== core/bfd_pkg.sv
package bfd_pkg;
   typedef logic [31:0] bfd_word_t;
   typedef logic [4:0] bfd_sel_t;
   typedef enum logic {bfd_relative, bfd_absolute} bfd_mode_e;
   typedef struct packed {
      logic [5:0] primary_opcode;
      logic [4:0] source_gpr_select;
      logic [4:0] target_gpr_select;
      logic [4:0] shift_gpr_select;
      logic [4:0] mask_begin;
      logic [4:0] mask_end;
      logic record_flag;
   } bfd_rot_s;
endpackage

// ===== core/bfd_field_if.sv
`timescale 1ns/1ps
interface bfd_field_if;
   import bfd_pkg::*;
   logic [23:0] long_branch_offset;
   logic [13:0] cond_branch_offset;
   logic absolute_address_flag;
   bfd_rot_s rot;
   bfd_sel_t tested_condition_bit;
   bfd_sel_t cond_source_bit_b;
   logic [2:0] cond_target_group;
   logic [2:0] cond_source_group;
   modport split (output long_branch_offset, cond_branch_offset, absolute_address_flag, rot,
      tested_condition_bit, cond_source_bit_b, cond_target_group, cond_source_group);
   modport use_side (input long_branch_offset, cond_branch_offset, absolute_address_flag, rot,
      tested_condition_bit, cond_source_bit_b, cond_target_group, cond_source_group);
endinterface

// ===== core/bfd_field_split.sv
`timescale 1ns/1ps
`include "bfd_map.svh"
module bfd_field_split
   import bfd_pkg::*;
(
   input wire logic [31:0] word,
   bfd_field_if.split f
);
   // big-endian bit n lives at little-endian index 31-n
   function automatic logic [31:0] pick(input logic [31:0] w, input int hi, input int lo);
      logic [31:0] r;
      r = '0;
      for (int k = hi; k <= lo; k++) begin
         r = {r[30:0], w[31-k]};
      end
      return r;
   endfunction

   always_comb begin
      f.rot.primary_opcode = 6'(pick(word, `BFD_OPC_HI, `BFD_OPC_LO));
      f.rot.source_gpr_select = 5'(pick(word, `BFD_F1_HI, `BFD_F1_LO));
      f.rot.target_gpr_select = 5'(pick(word, `BFD_F2_HI, `BFD_F2_LO));
      f.rot.shift_gpr_select = 5'(pick(word, `BFD_F3_HI, `BFD_F3_LO));
      f.rot.mask_begin = 5'(pick(word, `BFD_MB_HI, `BFD_MB_LO));
      f.rot.mask_end = 5'(pick(word, `BFD_ME_HI, `BFD_ME_LO));
      f.rot.record_flag = word[31-`BFD_RC_BIT];
      // sequences joined left to right, leftmost becomes msb
      f.long_branch_offset = 24'(pick(word, `BFD_LI_HI, `BFD_LI_LO));
      f.cond_branch_offset = 14'(pick(word, `BFD_BD_HI, `BFD_BD_LO));
      f.absolute_address_flag = word[31-`BFD_AA_BIT];
      f.tested_condition_bit = 5'(pick(word, `BFD_F2_HI, `BFD_F2_LO));
      f.cond_source_bit_b = 5'(pick(word, `BFD_F3_HI, `BFD_F3_LO));
      f.cond_target_group = 3'(pick(word, `BFD_F1_HI, `BFD_GRP_HI));
      f.cond_source_group = 3'(pick(word, `BFD_F2_HI, `BFD_SGRP_HI));
   end
endmodule

// ===== core/bfd_target_gen.sv
`timescale 1ns/1ps
`include "bfd_map.svh"
module bfd_target_gen
   import bfd_pkg::*;
#(
   parameter int ADDR_W = 64
)
(
   input wire logic [ADDR_W-1:0] cia,
   bfd_field_if.use_side f,
   output logic [ADDR_W-1:0] long_target,
   output logic [ADDR_W-1:0] cond_target
);
   if (ADDR_W != 32 && ADDR_W != 64) begin : g_width_check
      $error("address width must be 32 or 64");
   end

   logic [ADDR_W-1:0] li_ext;
   logic [ADDR_W-1:0] bd_ext;
   logic [ADDR_W-1:0] cia_al;
   logic [ADDR_W-1:0] long_sum;
   logic [ADDR_W-1:0] cond_sum;

   // two zero bits appended, then sign extension to the address width
   assign li_ext = ADDR_W'(signed'({f.long_branch_offset, 2'b00}));
   assign bd_ext = ADDR_W'(signed'({f.cond_branch_offset, 2'b00}));
   // fetch ignores low bits, so they are dropped before the add
   assign cia_al = {cia[ADDR_W-1:`BFD_ALIGN_BITS], `BFD_ALIGN_BITS'(0)};
   assign long_sum = cia_al + li_ext;
   assign cond_sum = cia_al + bd_ext;

   always_comb begin
      case (bfd_mode_e'(f.absolute_address_flag))
         bfd_relative: begin
            long_target = long_sum;
            cond_target = cond_sum;
         end
         bfd_absolute: begin
            long_target = li_ext;
            cond_target = bd_ext;
         end
         default: begin
            long_target = long_sum;
            cond_target = cond_sum;
         end
      endcase
   end
endmodule

// ===== core/bfd_branch_field_decoder.sv
`timescale 1ns/1ps
`include "bfd_map.svh"
module bfd_branch_field_decoder
   import bfd_pkg::*;
#(
   parameter int ADDR_W = 64
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic in_valid,
   input wire logic [31:0] in_word,
   input wire logic [ADDR_W-1:0] in_addr,
   input wire logic [31:0] reserved_mask,
   input wire logic [31:0] fixed_mask,
   input wire logic [31:0] fixed_value,
   output logic out_valid,
   output logic form_invalid,
   output logic [ADDR_W-1:0] long_target,
   output logic [ADDR_W-1:0] cond_target,
   output logic absolute_address_flag,
   output bfd_rot_s rot_fields,
   output logic [4:0] tested_condition_bit,
   output logic [4:0] cond_source_bit_b,
   output logic [4:0] cond_target_lsb,
   output logic [4:0] cond_source_lsb,
   output logic [31:0] cond_target_mask,
   output logic [31:0] cond_source_mask
);
   bfd_field_if fi();
   logic [ADDR_W-1:0] lt_c;
   logic [ADDR_W-1:0] ct_c;
   logic bad_c;

   // only the two documented widths have a sign-extension path
   if (ADDR_W != 32 && ADDR_W != 64) begin : g_width_check
      $error("address width must be 32 or 64");
   end

   bfd_field_split u_split (
      .word(in_word),
      .f(fi.split)
   );

   bfd_target_gen #(.ADDR_W(ADDR_W)) u_tgt (
      .cia(in_addr),
      .f(fi.use_side),
      .long_target(lt_c),
      .cond_target(ct_c)
   );

   // group g of the 32-bit register spans big-endian bits 4g..4g+3
   function automatic logic [31:0] group_mask(input logic [2:0] g);
      logic [31:0] m;
      m = '0;
      for (int k = 0; k < `BFD_GRP_BITS; k++) begin
         m[31 - (int'(g) * `BFD_GRP_BITS + k)] = 1'b1;
      end
      return m;
   endfunction

   // reserved and fixed-value layouts differ per instruction, so the caller supplies them
   assign bad_c = (|(in_word & reserved_mask))
      | (|((in_word ^ fixed_value) & fixed_mask));

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= in_valid;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         form_invalid <= 1'b0;
      end else if (in_valid) begin
         form_invalid <= bad_c;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         long_target <= '0;
         cond_target <= '0;
      end else if (in_valid) begin
         long_target <= lt_c;
         cond_target <= ct_c;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         absolute_address_flag <= 1'b0;
      end else if (in_valid) begin
         absolute_address_flag <= fi.absolute_address_flag;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rot_fields <= '0;
      end else if (in_valid) begin
         rot_fields <= fi.rot;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tested_condition_bit <= '0;
         cond_source_bit_b <= '0;
      end else if (in_valid) begin
         tested_condition_bit <= fi.tested_condition_bit;
         cond_source_bit_b <= fi.cond_source_bit_b;
      end
   end

   // start and mask both kept so users need no decode of their own
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cond_target_lsb <= '0;
         cond_source_lsb <= '0;
         cond_target_mask <= '0;
         cond_source_mask <= '0;
      end else if (in_valid) begin
         cond_target_lsb <= {fi.cond_target_group, 2'b00};
         cond_source_lsb <= {fi.cond_source_group, 2'b00};
         cond_target_mask <= group_mask(fi.cond_target_group);
         cond_source_mask <= group_mask(fi.cond_source_group);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_reserved_flag: assert property (
      in_valid && |(in_word & reserved_mask)
      |=> form_invalid)
      else $error("reserved bit set but form not invalid");

   a_fixed_flag: assert property (
      in_valid && |((in_word ^ fixed_value) & fixed_mask)
      |=> form_invalid)
      else $error("fixed field mismatch not flagged");

   a_clean_form: assert property (
      in_valid && !(|(in_word & reserved_mask))
      && !(|((in_word ^ fixed_value) & fixed_mask))
      |=> !form_invalid)
      else $error("clean word flagged invalid");

   a_valid_pulse: assert property (
      out_valid == $past(in_valid))
      else $error("result strobe not one cycle after request");

   a_rel_long: assert property (
      in_valid && !in_word[1]
      |=> long_target == ({$past(in_addr[ADDR_W-1:2]), 2'b00}
      + ADDR_W'(signed'({$past(in_word[25:2]), 2'b00}))))
      else $error("relative long target wrong");

   a_rel_cond: assert property (
      in_valid && !in_word[1]
      |=> cond_target == ({$past(in_addr[ADDR_W-1:2]), 2'b00}
      + ADDR_W'(signed'({$past(in_word[15:2]), 2'b00}))))
      else $error("relative conditional target wrong");

   a_abs_long: assert property (
      in_valid && in_word[1]
      |=> long_target == ADDR_W'(signed'({$past(in_word[25:2]), 2'b00})))
      else $error("absolute long target wrong");

   a_abs_cond: assert property (
      in_valid && in_word[1]
      |=> cond_target == ADDR_W'(signed'({$past(in_word[15:2]), 2'b00})))
      else $error("absolute conditional target wrong");

   a_long_sign: assert property (
      in_valid && in_word[1]
      |=> long_target[ADDR_W-1:25] == {(ADDR_W-25){$past(in_word[25])}})
      else $error("long offset sign not extended");

   a_cond_sign: assert property (
      in_valid && in_word[1]
      |=> cond_target[ADDR_W-1:15] == {(ADDR_W-15){$past(in_word[15])}})
      else $error("conditional offset sign not extended");

   a_cond_offset: assert property (
      in_valid && in_word[1]
      |=> cond_target[15:0] == {$past(in_word[15:2]), 2'b00})
      else $error("conditional offset bits misplaced");

   a_aa_bit: assert property (
      in_valid
      |=> absolute_address_flag == $past(in_word[1]))
      else $error("absolute flag not from bit 30");

   a_cond_bits: assert property (
      in_valid
      |=> tested_condition_bit == $past(in_word[20:16])
      && cond_source_bit_b == $past(in_word[15:11]))
      else $error("condition bit selectors wrong");

   a_group_sel: assert property (
      in_valid
      |=> cond_target_lsb == {$past(in_word[25:23]), 2'b00}
      && cond_source_lsb == {$past(in_word[20:18]), 2'b00})
      else $error("group selectors wrong");

   a_target_mask: assert property (
      in_valid
      |=> cond_target_mask == (32'hf000_0000 >> {$past(in_word[25:23]), 2'b00}))
      else $error("target group mask wrong");

   a_source_mask: assert property (
      in_valid
      |=> cond_source_mask == (32'hf000_0000 >> {$past(in_word[20:18]), 2'b00}))
      else $error("source group mask wrong");

   a_mask_lsb_match: assert property (
      out_valid
      |-> cond_target_mask[5'h1f - cond_target_lsb]
      && cond_source_mask[5'h1f - cond_source_lsb])
      else $error("group mask and group start disagree");

   a_mask_width: assert property (
      out_valid
      |-> $countones(cond_target_mask) == 4 && $countones(cond_source_mask) == 4)
      else $error("group mask not four bits wide");

   a_rot_split: assert property (
      in_valid
      |=> rot_fields.primary_opcode == $past(in_word[31:26])
      && rot_fields.mask_end == $past(in_word[5:1])
      && rot_fields.record_flag == $past(in_word[0]))
      else $error("rotate form split wrong");

   a_rot_regs: assert property (
      in_valid
      |=> rot_fields.source_gpr_select == $past(in_word[25:21])
      && rot_fields.target_gpr_select == $past(in_word[20:16])
      && rot_fields.shift_gpr_select == $past(in_word[15:11]))
      else $error("rotate register selects wrong");

   a_mask_begin: assert property (
      in_valid
      |=> rot_fields.mask_begin == $past(in_word[10:6]))
      else $error("rotate mask begin wrong");

   a_selector_alias: assert property (
      out_valid
      |-> tested_condition_bit == rot_fields.target_gpr_select
      && cond_source_bit_b == rot_fields.shift_gpr_select)
      else $error("condition selectors disagree with register fields");

   a_group_alias: assert property (
      out_valid
      |-> cond_target_lsb[4:2] == rot_fields.source_gpr_select[4:2]
      && cond_source_lsb[4:2] == rot_fields.target_gpr_select[4:2])
      else $error("group selectors disagree with register fields");

   a_flag_alias: assert property (
      out_valid
      |-> absolute_address_flag == rot_fields.mask_end[0])
      else $error("absolute flag disagrees with mask end field");

   a_target_align: assert property (
      out_valid
      |-> long_target[1:0] == 2'b00
      && cond_target[1:0] == 2'b00)
      else $error("target not word aligned");

   a_hold_idle: assert property (
      !in_valid
      |=> $stable(long_target) && $stable(form_invalid))
      else $error("outputs changed without a request");

   a_hold_fields: assert property (
      !in_valid
      |=> $stable(cond_target) && $stable(rot_fields)
      && $stable(cond_target_mask) && $stable(cond_source_mask))
      else $error("fields changed without a request");

   c_relative: cover property (in_valid && !in_word[1]);
   c_absolute: cover property (in_valid && in_word[1]);
   c_invalid: cover property (out_valid && form_invalid);
   c_fixed_mismatch: cover property (in_valid && |((in_word ^ fixed_value) & fixed_mask));
   c_back_to_back: cover property (in_valid [*2]);
endmodule

// ===== testbench/bfd_fetch_model.sv
`timescale 1ns/1ps
module bfd_fetch_model #(
   parameter int ADDR_W = 64
)
(
   input wire logic clk_sys,
   output logic in_valid,
   output logic [31:0] in_word,
   output logic [ADDR_W-1:0] in_addr
);
   initial begin
      in_valid = 1'b0;
      in_word = '0;
      in_addr = '0;
   end
   // gap lets the fetch side be prompt or slow
   task automatic issue(input logic [31:0] w, input logic [ADDR_W-1:0] a, input int gap);
      repeat (gap) @(posedge clk_sys);
      in_valid <= 1'b1;
      in_word <= w;
      in_addr <= a;
      @(posedge clk_sys);
      // released lines show inverted data, never a stale copy
      in_valid <= 1'b0;
      in_word <= ~w;
      in_addr <= ~a;
   endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
   import bfd_pkg::*;
   logic clk_sys, resetn, in_valid;
   logic [31:0] in_word, reserved_mask, fixed_mask, fixed_value, rnd;
   logic [63:0] in_addr, long_target, cond_target;
   logic out_valid, form_invalid, absolute_address_flag;
   bfd_rot_s rot_fields;
   logic [4:0] tested_condition_bit, cond_source_bit_b, cond_target_lsb, cond_source_lsb;
   logic [31:0] cond_target_mask, cond_source_mask;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   bfd_fetch_model #(.ADDR_W(64)) fetch (.clk_sys(clk_sys), .in_valid(in_valid), .in_word(in_word),
      .in_addr(in_addr));
   bfd_branch_field_decoder #(.ADDR_W(64)) DUT (.clk_sys(clk_sys), .resetn(resetn), .in_valid(in_valid),
      .in_word(in_word), .in_addr(in_addr), .reserved_mask(reserved_mask), .fixed_mask(fixed_mask),
      .fixed_value(fixed_value), .out_valid(out_valid), .form_invalid(form_invalid),
      .long_target(long_target), .cond_target(cond_target), .absolute_address_flag(absolute_address_flag),
      .rot_fields(rot_fields), .tested_condition_bit(tested_condition_bit),
      .cond_source_bit_b(cond_source_bit_b), .cond_target_lsb(cond_target_lsb),
      .cond_source_lsb(cond_source_lsb), .cond_target_mask(cond_target_mask),
      .cond_source_mask(cond_source_mask));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [63:0] exp_tgt(input logic ab, input logic [63:0] a, input logic [63:0] off);
      return ab ? off : {a[63:2], 2'b00} + off;
   endfunction
   task automatic end_sim();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         end_sim();
      end
   end
   task automatic run(input logic [31:0] w, input logic [63:0] a, input logic [31:0] rm, input logic [31:0] fm,
      input logic [31:0] fv, input int gap);
      logic [63:0] lo;
      logic [63:0] co;
      lo = {{38{w[25]}}, w[25:2], 2'b00};
      co = {{48{w[15]}}, w[15:2], 2'b00};
      @(posedge clk_sys);
      reserved_mask <= rm;
      fixed_mask <= fm;
      fixed_value <= fv;
      fetch.issue(w, a, gap);
      #1;
      `CHK("form_invalid", (|(w & rm)) || (|((w ^ fv) & fm)), form_invalid)
      `CHK("long_target", exp_tgt(w[1], a, lo), long_target)
      `CHK("cond_target", exp_tgt(w[1], a, co), cond_target)
      `CHK("abs_flag", w[1], absolute_address_flag)
      `CHK("rot_fields", w, rot_fields)
      `CHK("tested_bit", w[20:16], tested_condition_bit)
      `CHK("source_bit_b", w[15:11], cond_source_bit_b)
      `CHK("target_lsb", {w[25:23], 2'b00}, cond_target_lsb)
      `CHK("source_lsb", {w[20:18], 2'b00}, cond_source_lsb)
      `CHK("target_mask", 32'hf000_0000 >> {w[25:23], 2'b00}, cond_target_mask)
      `CHK("source_mask", 32'hf000_0000 >> {w[20:18], 2'b00}, cond_source_mask)
      `CHK("out_valid", 1'b1, out_valid)
      @(posedge clk_sys);
      #1;
      `CHK("out_valid_drop", 1'b0, out_valid)
      `CHK("invalid_hold", (|(w & rm)) || (|((w ^ fv) & fm)), form_invalid)
      `CHK("long_hold", exp_tgt(w[1], a, lo), long_target)
      `CHK("cond_hold", exp_tgt(w[1], a, co), cond_target)
      `CHK("rot_hold", w, rot_fields)
   endtask
   initial begin
      resetn = 1'b0;
      reserved_mask = '0;
      fixed_mask = '0;
      fixed_value = '0;
      rnd = 32'h0000_003b;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      // corner cases: sign edges, address wrap, both modes
      run(32'h0000_0000, 64'h0, 32'h0, 32'h0, 32'h0, 0);
      run(32'hffff_ffff, 64'h3, 32'h0, 32'h0, 32'h0, 0);
      run(32'h01ff_fffc, 64'hffff_ffff_ffff_fffd, 32'h0, 32'h0, 32'h0, 1);
      run(32'h0200_8000, 64'h0000_0000_0000_1002, 32'h0, 32'h0, 32'h0, 0);
      run(32'h0000_7ffe, 64'h7fff_ffff_ffff_fffc, 32'h0, 32'h0, 32'h0, 2);
      // single reserved bit set, then fixed field wrong and right
      run(32'h0000_0400, 64'h40, 32'h0000_0400, 32'h0, 32'h0, 0);
      run(32'h0000_0013, 64'h40, 32'hffff_0000, 32'h0000_00ff, 32'h0000_0012, 0);
      run(32'h0000_0012, 64'h40, 32'hffff_0000, 32'h0000_00ff, 32'h0000_0012, 0);
      for (int i = 0; i < 60; i++) begin
         logic [31:0] w, r1, r2, r3;
         rnd = lfsr(rnd);
         w = rnd;
         rnd = lfsr(rnd);
         r1 = rnd;
         rnd = lfsr(rnd);
         r2 = rnd;
         rnd = lfsr(rnd);
         r3 = rnd;
         // sparse masks so both valid and invalid forms occur
         run(w, {r1, r2}, r1 & r2 & r3, r2 & ~r3 & r1, w ^ (r3 & r1 & {32{i[0]}}), int'(r3[1:0]) % 3);
      end
      end_sim();
   end
endmodule
